// ### nibble_bus_pkg.sv
// Shared constants and types for the nibble-serial byte bus.
// Assumes both ends run on the same bus clock.
package nibble_bus_pkg;
	localparam logic [3:0] START_READ   = 4'hd;
	localparam logic [3:0] START_WRITE  = 4'he;
	localparam logic [3:0] SIZE_ONE     = 4'h0;
	localparam logic [3:0] TAR_ONES     = 4'hf;
	localparam logic [3:0] ABORT_CMD    = 4'hf;
	localparam logic [3:0] READY_SYNC   = 4'h0;
	localparam logic [3:0] ADDR_NIBBLES = 4'h7;
	localparam int         ADDR_W       = 28;
	localparam int         DEC_W        = 20;
	localparam int         ARRAY_SEL    = 22;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_SEL   = 4'b0001,
		ST_ADDR  = 4'b0010,
		ST_SIZE  = 4'b0011,
		ST_WD0   = 4'b0100,
		ST_WD1   = 4'b0101,
		ST_TURNAROUND_FIRST  = 4'b0110,
		ST_TURNAROUND_SECOND  = 4'b0111,
		ST_SYNC  = 4'b1000,
		ST_RD0   = 4'b1001,
		ST_RD1   = 4'b1010,
		ST_OTAR  = 4'b1011,
		ST_HTAR  = 4'b1100,
		ST_ABORT = 4'b1101
	} bus_state_t;
endpackage

// ### nibble_bus_if.sv
// Interface joining host and target over the nibble bus.
// Resolves the shared four-bit wire from both output enables (low = drive).
`timescale 1ns/1ns
`default_nettype none
interface nibble_bus_if;
	logic       frame_n;
	logic [3:0] host_out;
	logic       host_oe_n;
	logic [3:0] dev_out;
	logic       dev_oe_n;
	wire  [3:0] nibble_bus;

	assign nibble_bus = !host_oe_n ? host_out :
	                    !dev_oe_n  ? dev_out  : 4'hf;

	modport host (output frame_n, output host_out, output host_oe_n,
	              input nibble_bus);
	modport target (input frame_n, input nibble_bus, output dev_out,
	                output dev_oe_n);
endinterface
`default_nettype wire

// ### nibble_bus_target.sv
// Target end of the nibble bus: decodes single-byte reads and writes.
// Assumes the strap pins are steady and the flash core answers reads
// combinationally from the address it is given.
//
// Contract
// RULE1 - Fields are one nibble, one clock, bytes
// RULE2 - Start 1101 reads, 1110 writes, frame low
// RULE3 - Last start nibble before frame high counts
// RULE4 - Select nibble must match strap identity
// RULE5 - Mismatch: ignore cycle, return to standby
// RULE6 - Seven address nibbles, most significant first
// RULE7 - Size nibble in clock ten is zero
// RULE8 - Bad size: reset decoder, no response
// RULE9 - Decode low 20 bits; bit 22 selects
// RULE10 - Host drives ones then floats at turnaround
// RULE11 - Read clock 12 device takes bus
// RULE12 - Read clock 13 drives ready sync zero
// RULE13 - Read clocks 14,15 low then high nibble
// RULE14 - Clock 16 drives ones then floats
// RULE15 - Host resumes driving in clock 17
// RULE16 - Write data low nibble first, to command
// RULE17 - Write clock 14 device takes bus
// RULE18 - Write clock 15 drives sync zero ack
// RULE19 - Fields valid at rising clock edge
// RULE20 - Frame low mid-cycle aborts, await command
// RULE21 - Ones nibble after abort restores ready
// RULE22 - Host avoids abort during internal write
// RULE23 - Host checks write completion before abort
// RULE24 - Outputs float outside response clocks
`timescale 1ns/1ns
`default_nettype none
module nibble_bus_target (
	// Clock and reset.
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_n,
	// Bus pins.
	nibble_bus_if.target                      bus,
	// Strap identity.
	input  wire logic [3:0]                   i_strap_identity,
	// Flash core side.
	output logic      [nibble_bus_pkg::DEC_W-1:0] o_addr,
	output logic                              o_array_sel,
	input  wire logic [7:0]                   i_rd_data,
	output logic                              o_rd_strobe,
	output logic                              o_wr_strobe,
	output logic      [7:0]                   o_wr_data
);
	import nibble_bus_pkg::*;

	bus_state_t              state_reg;
	logic                    is_write_reg;
	logic [ADDR_W-1:0]       addr_reg;
	logic [3:0]              cnt_reg;
	logic [7:0]              rd_byte_reg;
	logic [7:0]              wr_byte_reg;
	logic                    wr_stb_reg;
	logic                    rd_stb_reg;
	logic [3:0]              out_reg;
	logic                    oe_n_reg;

	wire logic [3:0] nib   = bus.nibble_bus;
	wire logic       frame = !bus.frame_n;

	function automatic logic is_start(input logic [3:0] code);
		return (code == START_READ) || (code == START_WRITE);
	endfunction

	// ------------------------------------------------------------------
	// Cycle decoder
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin // [RULE19]
		if (!i_rst_n) begin
			state_reg    <= ST_IDLE;
			is_write_reg <= 1'b0;
			cnt_reg      <= 4'h0;
		end else if (frame && state_reg != ST_IDLE &&
		             state_reg != ST_SEL && state_reg != ST_ABORT) begin
			state_reg <= ST_ABORT; // [RULE20]
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (frame && is_start(nib)) begin // [RULE2]
						state_reg    <= ST_SEL;
						is_write_reg <= (nib == START_WRITE);
					end
				end
				ST_SEL: begin
					if (frame) begin
						// Frame still low: a later start code replaces this one.
						if (is_start(nib))
							is_write_reg <= (nib == START_WRITE); // [RULE3]
						else
							state_reg <= ST_IDLE;
					end else if (nib == i_strap_identity) begin // [RULE4]
						state_reg <= ST_ADDR;
						cnt_reg   <= 4'h1;
					end else
						state_reg <= ST_IDLE; // [RULE5]
				end
				ST_ADDR: begin
					if (cnt_reg == ADDR_NIBBLES)
						state_reg <= ST_SIZE;
					cnt_reg <= cnt_reg + 4'h1;
				end
				ST_SIZE: begin
					if (nib != SIZE_ONE)
						state_reg <= ST_IDLE; // [RULE8]
					else if (is_write_reg)
						state_reg <= ST_WD0; // [RULE7]
					else
						state_reg <= ST_TURNAROUND_FIRST;
				end
				ST_WD0:  state_reg <= ST_WD1;
				ST_WD1:  state_reg <= ST_TURNAROUND_FIRST;
				ST_TURNAROUND_FIRST: state_reg <= ST_TURNAROUND_SECOND; // [RULE10]
				ST_TURNAROUND_SECOND: state_reg <= ST_SYNC;
				ST_SYNC: state_reg <= is_write_reg ? ST_OTAR : ST_RD0;
				ST_RD0:  state_reg <= ST_RD1;
				ST_RD1:  state_reg <= ST_OTAR;
				ST_OTAR: state_reg <= ST_HTAR;
				ST_HTAR: state_reg <= ST_IDLE; // [RULE15]
				ST_ABORT: begin
					if (!frame && nib == ABORT_CMD)
						state_reg <= ST_IDLE; // [RULE21]
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Address and data capture
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			addr_reg <= '0;
		else if (state_reg == ST_ADDR)
			addr_reg <= {addr_reg[ADDR_W-5:0], nib}; // [RULE6]
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			wr_byte_reg <= 8'h00;
		else if (state_reg == ST_WD0)
			wr_byte_reg[3:0] <= nib; // [RULE16]
		else if (state_reg == ST_WD1)
			wr_byte_reg[7:4] <= nib; // [RULE1]
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_stb_reg  <= 1'b0;
			rd_stb_reg  <= 1'b0;
			rd_byte_reg <= 8'h00;
		end else begin
			// Command logic gets the byte once the sync is returned.
			wr_stb_reg <= !frame && state_reg == ST_SYNC && is_write_reg;
			rd_stb_reg <= !frame && state_reg == ST_TURNAROUND_FIRST && !is_write_reg;
			if (state_reg == ST_TURNAROUND_SECOND)
				rd_byte_reg <= i_rd_data;
		end
	end

	// ------------------------------------------------------------------
	// Output drivers
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_reg  <= TAR_ONES;
			oe_n_reg <= 1'b1;
		end else if (frame) begin
			out_reg  <= TAR_ONES;
			oe_n_reg <= 1'b1; // [RULE24]
		end else begin
			case (state_reg)
				ST_TURNAROUND_SECOND: begin
					out_reg  <= READY_SYNC; // [RULE11] [RULE12] [RULE17] [RULE18]
					oe_n_reg <= 1'b0;
				end
				ST_SYNC: begin
					out_reg  <= is_write_reg ? TAR_ONES : rd_byte_reg[3:0]; // [RULE13]
					oe_n_reg <= 1'b0;
				end
				ST_RD0: begin
					out_reg  <= rd_byte_reg[7:4]; // [RULE13]
					oe_n_reg <= 1'b0;
				end
				ST_RD1: begin
					out_reg  <= TAR_ONES; // [RULE14]
					oe_n_reg <= 1'b0;
				end
				default: begin
					out_reg  <= TAR_ONES;
					oe_n_reg <= 1'b1; // [RULE24]
				end
			endcase
		end
	end

	assign bus.dev_out  = out_reg;
	assign bus.dev_oe_n = oe_n_reg;
	assign o_addr       = addr_reg[DEC_W-1:0]; // [RULE9]
	assign o_array_sel  = addr_reg[ARRAY_SEL];
	assign o_wr_data    = wr_byte_reg;
	assign o_wr_strobe  = wr_stb_reg;
	assign o_rd_strobe  = rd_stb_reg;
endmodule
`default_nettype wire

// ### nibble_bus_host.sv
// Host end of the nibble bus: runs one single-byte read or write.
// Assumes one target answers; a missing sync ends the cycle as an error.
`timescale 1ns/1ns
`default_nettype none
module nibble_bus_host (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Bus pins.
	nibble_bus_if.host       bus,
	// Request.
	input  wire logic        i_start,
	input  wire logic        i_write,
	input  wire logic [3:0]  i_select,
	input  wire logic [27:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_abort,
	// Answer.
	output logic             o_busy,
	output logic             o_done,
	output logic             o_error,
	output logic      [7:0]  o_rdata
);
	import nibble_bus_pkg::*;

	logic [4:0]  clk_reg;
	logic        run_reg;
	logic        wr_reg;
	logic        abt_reg;
	logic [47:0] sh_reg;
	logic [7:0]  rd_reg;
	logic        done_reg;
	logic        err_reg;
	logic [3:0]  drv;
	logic        drv_en;
	logic        fr_low;

	// Clock number 1..17 of the cycle; host drives up to its turnaround.
	always_comb begin
		drv    = sh_reg[47:44];
		drv_en = 1'b0;
		fr_low = 1'b0;
		if (abt_reg) begin
			drv    = ABORT_CMD; // [RULE21]
			drv_en = 1'b1;
		end else if (run_reg) begin
			fr_low = (clk_reg == 5'd1);
			drv_en = wr_reg ? (clk_reg <= 5'd13) : (clk_reg <= 5'd11); // [RULE10]
			if (clk_reg == 5'd17)
				drv_en = 1'b1; // [RULE15]
			if (clk_reg >= 5'd17)
				drv = TAR_ONES;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_reg  <= 1'b0;
			abt_reg  <= 1'b0;
			clk_reg  <= 5'd0;
			wr_reg   <= 1'b0;
			sh_reg   <= '0;
			rd_reg   <= 8'h00;
			done_reg <= 1'b0;
			err_reg  <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			abt_reg  <= 1'b0;
			if (i_abort) begin
				// Caller waits out any internal write first.
				run_reg <= 1'b0; // [RULE22] [RULE23]
				abt_reg <= 1'b1;
			end else if (!run_reg && i_start) begin
				run_reg <= 1'b1;
				wr_reg  <= i_write;
				clk_reg <= 5'd1;
				sh_reg  <= {i_write ? START_WRITE : START_READ, i_select,
				            i_addr, SIZE_ONE,
				            i_write ? {i_wdata[3:0], i_wdata[7:4]} : 8'hff};
			end else if (run_reg) begin
				clk_reg <= clk_reg + 5'd1;
				sh_reg  <= {sh_reg[43:0], TAR_ONES};
				if (!wr_reg && clk_reg == 5'd14)
					rd_reg[3:0] <= bus.nibble_bus;
				if (!wr_reg && clk_reg == 5'd15)
					rd_reg[7:4] <= bus.nibble_bus;
				if (clk_reg == (wr_reg ? 5'd15 : 5'd13))
					err_reg <= (bus.nibble_bus != READY_SYNC);
				if (clk_reg == 5'd17) begin
					run_reg  <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

	assign bus.frame_n   = !(fr_low || abt_reg);
	assign bus.host_out  = drv;
	assign bus.host_oe_n = !drv_en;
	assign o_busy        = run_reg;
	assign o_done        = done_reg;
	assign o_error       = err_reg;
	assign o_rdata       = rd_reg;
endmodule
`default_nettype wire

// ### nibble_bus_chk.sv
// Checker for the nibble bus between the host and target ends.
// Assumes it sees the interface signals on the one bus clock.
`timescale 1ns/1ns
`default_nettype none
module nibble_bus_chk
	import nibble_bus_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       frame_n,
	input wire logic [3:0] host_out,
	input wire logic       host_oe_n,
	input wire logic [3:0] dev_out,
	input wire logic       dev_oe_n,
	input wire logic [3:0] nibble_bus
);
	// ------
	// Field number of the clock now sampled, and the last nibble seen with frame low (start or abort code).
	// ------
	logic [4:0] cnt_reg;
	logic [3:0] kind_reg;
	logic       rd;
	logic       wr;
	assign rd = (kind_reg == START_READ);
	assign wr = (kind_reg == START_WRITE);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			cnt_reg <= 5'h00;
		else if (!frame_n)
			cnt_reg <= 5'h02;
		else if (cnt_reg != 5'h00 && cnt_reg != 5'h11)
			cnt_reg <= cnt_reg + 5'h01;
		else
			cnt_reg <= 5'h00;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			kind_reg <= 4'h0;
		else if (!frame_n)
			kind_reg <= nibble_bus;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ------
	// Assertions.
	// ------
	no_clash_a: assert property (host_oe_n || dev_oe_n)
		else $error("both ends drive the bus");
	dev_window_a: assert property (
		!dev_oe_n |->
		(rd && cnt_reg >= 5'h0d && cnt_reg <= 5'h10) ||
		(wr && cnt_reg >= 5'h0f && cnt_reg <= 5'h10))
		else $error("target drives outside its response clocks");
	rd_sync_a: assert property (
		rd && cnt_reg == 5'h0d && !dev_oe_n |->
		dev_out == READY_SYNC ##1 !dev_oe_n [*2] ##1
		(!dev_oe_n && dev_out == TAR_ONES) ##1 dev_oe_n)
		else $error("read response sequence wrong");
	wr_sync_a: assert property (
		wr && cnt_reg == 5'h0f && !dev_oe_n |->
		dev_out == READY_SYNC ##1
		(!dev_oe_n && dev_out == TAR_ONES) ##1 dev_oe_n)
		else $error("write response sequence wrong");
	rd_tar_a: assert property (
		rd && cnt_reg == 5'h0b |->
		!host_oe_n && host_out == TAR_ONES ##1 host_oe_n)
		else $error("host read turnaround wrong");
	wr_tar_a: assert property (
		wr && cnt_reg == 5'h0d |->
		!host_oe_n && host_out == TAR_ONES ##1 host_oe_n)
		else $error("host write turnaround wrong");
	host_resume_a: assert property (
		cnt_reg == 5'h11 && !$past(dev_oe_n) |-> !host_oe_n)
		else $error("host did not resume the bus");
	size_zero_a: assert property (
		(rd || wr) && cnt_reg == 5'h0a |-> nibble_bus == SIZE_ONE)
		else $error("size field not one byte");
	idle_float_a: assert property (cnt_reg == 5'h00 |-> dev_oe_n)
		else $error("target drives while idle");
	abort_float_a: assert property (
		kind_reg == ABORT_CMD && cnt_reg != 5'h00 |-> dev_oe_n)
		else $error("target drives after an abort");
	cover property (rd && cnt_reg == 5'h0d && !dev_oe_n);
	cover property (wr && cnt_reg == 5'h0f && !dev_oe_n);
	cover property (kind_reg == ABORT_CMD && cnt_reg == 5'h02);
	cover property (rd && cnt_reg == 5'h0d && dev_oe_n);
endmodule
`default_nettype wire

// ### tb.sv
// Testbench joining the host and target ends over the nibble bus.
// Assumes a flash core that answers reads from the address at once.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import nibble_bus_pkg::*;
	logic        i_clk, i_rst_n, i_start, i_write, i_abort;
	logic        o_busy, o_done, o_error, o_array_sel;
	logic        o_rd_strobe, o_wr_strobe;
	logic [3:0]  i_select, strap_identity;
	logic [27:0] i_addr;
	logic [7:0]  i_wdata, o_rdata, rd_data, o_wr_data;
	logic [DEC_W-1:0] o_addr;
	int          errors, cmp_count, rd_seen, wr_seen, i, n;
	nibble_bus_if bus();
	nibble_bus_host nibble_bus_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.bus(bus), .i_start(i_start), .i_write(i_write),
		.i_select(i_select), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_abort(i_abort), .o_busy(o_busy), .o_done(o_done),
		.o_error(o_error), .o_rdata(o_rdata));
	nibble_bus_target nibble_bus_target_inst (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .bus(bus), .i_strap_identity(strap_identity),
		.o_addr(o_addr), .o_array_sel(o_array_sel), .i_rd_data(rd_data),
		.o_rd_strobe(o_rd_strobe), .o_wr_strobe(o_wr_strobe),
		.o_wr_data(o_wr_data));
	nibble_bus_chk nibble_bus_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.frame_n(bus.frame_n), .host_out(bus.host_out),
		.host_oe_n(bus.host_oe_n), .dev_out(bus.dev_out),
		.dev_oe_n(bus.dev_oe_n), .nibble_bus(bus.nibble_bus));
	// The flash core answers with a byte derived from the address.
	assign rd_data = o_addr[7:0] ^ 8'h5a;
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_rd_strobe === 1'b1) rd_seen++;
		if (o_wr_strobe === 1'b1) wr_seen++;
	end
	task close_out;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wait_low(input logic busy_wait);
		for (n = 0; n < 40 && (busy_wait ? o_busy !== 1'b0 : o_done !== 1'b1); n++)
			@(negedge i_clk);
		if (n == 40) begin
			errors++;
			close_out();
		end
	endtask
	task launch(input logic w, input logic [3:0] sel, input logic [27:0] a,
	            input logic [7:0] d);
		@(negedge i_clk);
		i_write = w;
		i_select = sel;
		i_addr = a;
		i_wdata = d;
		i_start = 1'b1;
		@(negedge i_clk);
		i_start = 1'b0;
	endtask
	task xfer(input logic w, input logic [3:0] sel, input logic [27:0] a,
	          input logic [7:0] d);
		launch(w, sel, a, d);
		wait_low(1'b0);
	endtask
	initial begin
		errors = 0;
		cmp_count = 0;
		rd_seen = 0;
		wr_seen = 0;
		i_rst_n = 1'b0;
		i_start = 1'b0;
		i_write = 1'b0;
		i_abort = 1'b0;
		i_select = 4'h0;
		i_addr = 28'h0000000;
		i_wdata = 8'h00;
		strap_identity = 4'h3;
		repeat (6) @(negedge i_clk);
		i_rst_n = 1'b1;
		xfer(1'b0, 4'h3, 28'hf45a5c3, 8'h00);
		chk(o_rdata, 8'h99);
		chk(o_addr, 20'h5a5c3);
		chk(o_array_sel, 1'b1);
		chk(o_error, 1'b0);
		chk(rd_seen, 1);
		xfer(1'b1, 4'h3, 28'h0b12345, 8'h3c);
		chk(o_wr_data, 8'h3c);
		chk(o_addr, 20'h12345);
		chk(o_array_sel, 1'b0);
		chk(wr_seen, 1);
		chk(o_error, 1'b0);
		xfer(1'b0, 4'h4, 28'h0400000, 8'h00);
		chk(o_error, 1'b1);
		chk(rd_seen, 1);
		for (i = 0; i < 16; i++) begin
			strap_identity = i[3:0];
			xfer(1'b0, i[3:0], {24'h040000, i[3:0]}, 8'h00);
			chk(o_rdata, {4'h0, i[3:0]} ^ 8'h5a);
			chk(o_error, 1'b0);
		end
		strap_identity = 4'h3;
		launch(1'b0, 4'h3, 28'h0400011, 8'h00);
		repeat (4) @(negedge i_clk);
		i_abort = 1'b1;
		@(negedge i_clk);
		i_abort = 1'b0;
		wait_low(1'b1);
		chk(rd_seen, 17);
		xfer(1'b0, 4'h3, 28'h0400022, 8'h00);
		chk(o_rdata, 8'h78);
		chk(o_error, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
